// ### core/sfss_top.sv
// strap-selected synthesizer control, lock/reset indicator and pulse timing
`timescale 1ns/1ns
module sfss_top #(
  parameter int unsigned LOCK_CYC = sfss_pkg::LOCK_CYCLES,
  parameter int unsigned SEC_CYC = sfss_pkg::SEC_CYCLES,
  parameter int unsigned PPS_HIGH_CYC = sfss_pkg::PPS_HIGH_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ext_reset_n_in,
  input wire logic [2:0] synth_select_straps_grounded_in,
  input wire logic nmea_rate_grounded_in,
  input wire sfss_pkg::sfss_ref_t ref_freq_sel_in,
  input wire logic pps_raw_in,
  input wire logic synth_pin_in,
  output logic synth_pin_out,
  output logic synth_pin_oe_out,
  output logic synth_locked_reset_n_out,
  output logic program_mode_enable_n_out,
  output logic [2:0] synth_select_straps_out,
  output logic nmea_rate_5hz_out,
  output logic nmea_tick_out,
  output logic pps_raw_out,
  output logic pps_clean_out,
  output logic fix_enable_out
);
  import sfss_pkg::*;

  // lock sequencer states
  typedef enum logic [0:0] {
    ST_WAIT = 1'b0,
    ST_RUN = 1'b1
  } sfss_state_t;

  // nine pins synchronised: reset, three straps, rate, pps, shared pin, reference
  localparam int unsigned SYN_W = 9;

  // synchroniser stages
  logic [SYN_W-1:0] sync1_r;
  logic [SYN_W-1:0] sync2_r;

  // sequencer and captured selection
  sfss_state_t state_r;
  logic [CNT_W-1:0] lock_cnt_r;
  logic [2:0] code_r;
  sfss_ref_t ref_r;
  logic rate5_r;
  logic prog_n_r;
  logic cold_r;

  // second, sentence and blanking timers
  logic [CNT_W-1:0] sec_cnt_r;
  logic [CNT_W-1:0] nmea_cnt_r;
  logic nmea_tick_r;
  logic pps_raw_r;
  logic pps_clean_r;
  logic [5:0] fix_sec_r;
  logic fix_en_r;
  logic synth_wave;

  // pins from outside pass two flip-flops first
  // only the second stage is read, the first may still be settling
  wire [SYN_W-1:0] raw_pins = {ext_reset_n_in, synth_select_straps_grounded_in,
                               nmea_rate_grounded_in, pps_raw_in, synth_pin_in, ref_freq_sel_in};
  // reset pin stages reset released so a power-on is not taken for a pin reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1_r <= {1'b1, {(SYN_W-1){1'b0}}};
      sync2_r <= {1'b1, {(SYN_W-1){1'b0}}};
    end else begin
      sync1_r <= raw_pins;
      sync2_r <= sync1_r;
    end
  end

  // decoded synchronised pins
  // grounded external reset restarts the lock hold, sentence tick, fix blanking and synthesizer; the pps timing runs on
  wire ext_rst = ~sync2_r[8];
  // a floating strap is pulled up so it is not grounded and reads 1
  wire [2:0] strap_code = ~sync2_r[7:5];
  wire rate_fast = sync2_r[4];
  wire pps_s = sync2_r[3];
  wire pin_s = sync2_r[2];
  wire sfss_ref_t ref_s = sfss_ref_t'(sync2_r[1:0]);

  // timing decode
  // indicator released after the full hold time
  wire lock_done = (lock_cnt_r == CNT_W'(LOCK_CYC - 1));
  // raw edge found on the synchronised level against its delayed copy
  wire pps_edge = pps_s & ~pps_raw_r;
  wire sec_wrap = (sec_cnt_r == CNT_W'(SEC_CYC - 1));
  // a raw edge restarts the second, so it is not counted twice
  wire sec_tick = sec_wrap & ~pps_edge;
  // sentence period follows the captured rate strap
  wire [CNT_W-1:0] nmea_last = rate5_r ? CNT_W'(SEC_CYC / NMEA_FAST_HZ - 1) : CNT_W'(SEC_CYC / NMEA_SLOW_HZ - 1);
  wire nmea_wrap = (nmea_cnt_r >= nmea_last);
  // blanking length depends on how the reset came
  wire [5:0] fix_limit = cold_r ? COLD_FIX_S : WARM_FIX_S;

  // run state doubles as the lock indicator
  wire run = (state_r == ST_RUN);
  // code 111 keeps the synthesizer off
  wire synth_en = run && (code_r != SEL_OFF);

  // lock sequencer: hold, then sample and run until next reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_r <= ST_WAIT;
      lock_cnt_r <= '0;
    end else if (ext_rst) begin
      state_r <= ST_WAIT;
      lock_cnt_r <= '0;
    end else if (state_r == ST_WAIT) begin
      // counter stops in run so the hold cannot restart by wrapping
      // one hold period, then high until the next reset
      state_r <= lock_done ? ST_RUN : ST_WAIT;
      lock_cnt_r <= lock_cnt_r + 1'b1;
    end
  end

  // strap and pin capture at the end of the hold, while the pin is still undriven
  // limitation: a strap moved after the hold counts only at the next reset
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      code_r <= SEL_OFF;
      ref_r <= REF_20M;
      rate5_r <= 1'b0;
      prog_n_r <= 1'b1;
    end else if (state_r == ST_WAIT && lock_done && !ext_rst) begin
      // one sample per reset, held afterwards
      code_r <= strap_code;
      // decode uses the reference actually fitted
      ref_r <= ref_s;
      rate5_r <= rate_fast;
      // pin level read as the active-low programming enable
      prog_n_r <= pin_s;
    end
  end

  // cold flag: power-on is cold, a pin reset is warm
  // a pin reset never sets it back, only a power-on does
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cold_r <= 1'b1;
    end else if (ext_rst) begin
      cold_r <= 1'b0;
    end
  end

  // clean pulse phase restarts on every raw rising edge
  // free runs without raw pulses so the clean output keeps going in holdover
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sec_cnt_r <= '0;
      pps_raw_r <= 1'b0;
      pps_clean_r <= 1'b0;
    end else begin
      pps_raw_r <= pps_s;
      sec_cnt_r <= (pps_edge || sec_wrap) ? '0 : sec_cnt_r + 1'b1;
      pps_clean_r <= (pps_edge || sec_wrap) ? 1'b1 : (sec_cnt_r < CNT_W'(PPS_HIGH_CYC - 1)) && pps_clean_r;
    end
  end

  // sentence tick, free running once the module is up
  // held at zero until run, so the first tick is one full period after lock
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      nmea_cnt_r <= '0;
      nmea_tick_r <= 1'b0;
    end else if (ext_rst || !run) begin
      nmea_cnt_r <= '0;
      nmea_tick_r <= 1'b0;
    end else begin
      nmea_cnt_r <= nmea_wrap ? '0 : nmea_cnt_r + 1'b1;
      nmea_tick_r <= nmea_wrap;
    end
  end

  // fixes withheld for whole seconds after each reset
  // whole seconds only: the partial first second is traded for a small counter
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      fix_sec_r <= '0;
      fix_en_r <= 1'b0;
    end else if (ext_rst) begin
      fix_sec_r <= '0;
      fix_en_r <= 1'b0;
    end else if (!fix_en_r && sec_tick) begin
      fix_sec_r <= fix_sec_r + 1'b1;
      fix_en_r <= (fix_sec_r + 1'b1) >= fix_limit;
    end
  end

  // ratio picked from the held code and reference
  wire sfss_ratio_t ratio = sfss_ratio(ref_r, code_r);

  // synthesizer restarts with the sequencer so its phase starts clean after lock
  sfss_nm_synth u_synth (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .restart_in(ext_rst),
    .enable_in(synth_en),
    .ratio_in(ratio),
    .synth_out(synth_wave)
  );

  // outputs; pin left undriven through the hold so it can be sampled
  // drive starts at the same edge the indicator rises
  assign synth_pin_out = synth_wave;
  assign synth_pin_oe_out = synth_en;
  // indicator is low until the output is stable
  // it is the run state itself, so it cannot glitch high during the hold
  assign synth_locked_reset_n_out = run;
  // captured values and timer pulses, all straight from flip-flops
  assign program_mode_enable_n_out = prog_n_r;
  assign synth_select_straps_out = code_r;
  assign nmea_rate_5hz_out = rate5_r;
  assign nmea_tick_out = nmea_tick_r;
  assign pps_raw_out = pps_raw_r;
  assign pps_clean_out = pps_clean_r;
  assign fix_enable_out = fix_en_r;
endmodule

// ### core/sfss_pkg.sv
// constants, types and ratio decode for the strap-selected synthesizer control
package sfss_pkg;

  // clock and derived timing
  localparam int unsigned CLK_HZ = 32'h05F5_E100; // 100 MHz
  localparam int unsigned CLK_PER_MS = CLK_HZ / 32'h0000_03E8;
  localparam int unsigned LOCK_TIME_MS = 32'h0000_03E8; // 1000 ms
  localparam int unsigned LOCK_CYCLES = LOCK_TIME_MS * CLK_PER_MS;
  localparam int unsigned SEC_TIME_MS = 32'h0000_03E8; // 1000 ms
  localparam int unsigned SEC_CYCLES = SEC_TIME_MS * CLK_PER_MS;
  localparam int unsigned PPS_HIGH_MS = 32'h0000_0064; // 100 ms
  localparam int unsigned PPS_HIGH_CYCLES = PPS_HIGH_MS * CLK_PER_MS;
  localparam int unsigned NMEA_SLOW_HZ = 32'h0000_0001;
  localparam int unsigned NMEA_FAST_HZ = 32'h0000_0005;
  localparam logic [5:0] COLD_FIX_S = 6'h23; // 35 s
  localparam logic [5:0] WARM_FIX_S = 6'h03; // 3 s
  localparam int unsigned CNT_W = 27;

  // strap code that turns the synthesizer off
  localparam logic [2:0] SEL_OFF = 3'h7;

  // synthesizer accumulator: output = clk * num / (2 * den * 2**SCALE_LOG2)
  localparam int unsigned SCALE_LOG2 = 4;
  localparam int unsigned ACC_W = 9;

  typedef enum logic [1:0] {
    REF_10M = 2'h0,
    REF_15M36 = 2'h1,
    REF_19M2 = 2'h2,
    REF_20M = 2'h3
  } sfss_ref_t;

  typedef struct packed {
    logic [3:0] num;
    logic [3:0] den;
  } sfss_ratio_t;

  // ratio of output to reference; code 111 gives zero
  function automatic sfss_ratio_t sfss_ratio(input sfss_ref_t r, input logic [2:0] c);
    sfss_ratio_t q;
    q = '{num: 4'h0, den: 4'h1};
    case (r)
      REF_10M: begin
        case (c)
          3'h6: q = '{num: 4'h1, den: 4'h2};
          3'h5: q = '{num: 4'h4, den: 4'h3};
          3'h4: q = '{num: 4'h8, den: 4'h5};
          3'h3: q = '{num: 4'h2, den: 4'h1};
          3'h2: q = '{num: 4'h8, den: 4'h3};
          3'h1: q = '{num: 4'h4, den: 4'h1};
          3'h0: q = '{num: 4'h8, den: 4'h1};
          default: q = '{num: 4'h0, den: 4'h1};
        endcase
      end
      REF_15M36: begin
        case (c)
          3'h6: q = '{num: 4'h3, den: 4'hA};
          3'h5: q = '{num: 4'h2, den: 4'h3};
          3'h4: q = '{num: 4'h1, den: 4'h1};
          3'h3: q = '{num: 4'h3, den: 4'h2};
          3'h2: q = '{num: 4'h2, den: 4'h1};
          3'h1: q = '{num: 4'h3, den: 4'h1};
          3'h0: q = '{num: 4'h6, den: 4'h1};
          default: q = '{num: 4'h0, den: 4'h1};
        endcase
      end
      // 19.2 and 20 megahertz share one column
      default: begin
        case (c)
          3'h6: q = '{num: 4'h1, den: 4'h4};
          3'h5: q = '{num: 4'h1, den: 4'h2};
          3'h4: q = '{num: 4'h2, den: 4'h3};
          3'h3: q = '{num: 4'h4, den: 4'h5};
          3'h2: q = '{num: 4'h4, den: 4'h3};
          3'h1: q = '{num: 4'h2, den: 4'h1};
          3'h0: q = '{num: 4'h4, den: 4'h1};
          default: q = '{num: 4'h0, den: 4'h1};
        endcase
      end
    endcase
    return q;
  endfunction

endpackage

// ### core/sfss_nm_synth.sv
// n/m fractional synthesizer built on a phase accumulator
`timescale 1ns/1ns
module sfss_nm_synth (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic restart_in,
  input wire logic enable_in,
  input wire sfss_pkg::sfss_ratio_t ratio_in,
  output logic synth_out
);
  import sfss_pkg::*;

  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;
  logic wave_r;

  // wrap limit scales den so the fastest ratio stays well below clk/2
  wire [ACC_W-1:0] limit = ACC_W'({ratio_in.den, {SCALE_LOG2{1'b0}}});
  wire [ACC_W-1:0] sum = acc_r + ACC_W'(ratio_in.num);
  wire wrap = (sum >= limit);
  assign acc_nxt = wrap ? (sum - limit) : sum;

  // output edges derive only from the reference clock
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc_r <= '0;
      wave_r <= 1'b0;
    end else if (restart_in || !enable_in) begin
      acc_r <= '0;
      wave_r <= 1'b0;
    end else begin
      acc_r <= acc_nxt;
      wave_r <= wave_r ^ wrap;
    end
  end

  assign synth_out = wave_r;
endmodule

// ### bench/sfss_sva.sv
// concurrent checks on the synthesizer control ports
`timescale 1ns/1ns
module sfss_sva #(
  parameter int unsigned LOCK_CYC = sfss_pkg::LOCK_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ext_reset_n_in,
  input wire logic synth_pin_out,
  input wire logic synth_pin_oe_out,
  input wire logic synth_locked_reset_n_out,
  input wire logic [2:0] synth_select_straps_out,
  input wire logic nmea_tick_out,
  input wire logic pps_raw_out,
  input wire logic pps_clean_out
);
  import sfss_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire lk = synth_locked_reset_n_out;
  wire off = synth_select_straps_out == SEL_OFF;
  logic [CNT_W-1:0] low_r;
  // cycles spent with lock low, cleared once locked
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      low_r <= '0;
    end else if (lk) begin
      low_r <= '0;
    end else begin
      low_r <= low_r + 1'b1;
    end
  end
  off_quiet_a: assert property (off |-> !synth_pin_oe_out && !synth_pin_out) else $error("pin driven while off");
  oe_on_a: assert property (lk && !off |-> synth_pin_oe_out) else $error("no output after lock");
  straps_hold_a: assert property (lk && $past(lk) |-> $stable(synth_select_straps_out)) else $error("code moved");
  lock_keep_a: assert property (lk && ext_reset_n_in |=> lk) else $error("lock dropped");
  lock_wait_a: assert property ($rose(lk) |-> low_r >= CNT_W'(LOCK_CYC)) else $error("lock too early");
  ext_reset_a: assert property ($fell(ext_reset_n_in) ##1 !ext_reset_n_in [*2] |=> !lk) else $error("no restart");
  pps_align_a: assert property ($rose(pps_raw_out) |-> pps_clean_out) else $error("pps not aligned");
  pps_width_a: assert property ($rose(pps_clean_out) |=> pps_clean_out [*8]) else $error("clean pps short");
  // sentence tick single cycle, running only
  tick_pulse_a: assert property (nmea_tick_out |-> lk ##1 !nmea_tick_out) else $error("bad sentence tick");
  c_lock: cover property ($rose(lk));
  c_ext: cover property ($fell(ext_reset_n_in));
  c_pps: cover property ($rose(pps_clean_out));
endmodule

// ### bench/sfss_board_model.sv
// board side: pull-up buffer on the shared pin and an edge counter
`timescale 1ns/1ns
module sfss_board_model (
  input wire logic clk_in,
  input wire logic clr_in,
  input wire logic pin_out_in,
  input wire logic pin_oe_in,
  output logic pin_level_out,
  output int edges_out
);
  logic last_r;
  // released pin floats high, never pulled low
  assign pin_level_out = pin_oe_in ? pin_out_in : 1'b1;
  // rising edges of the synthesized wave, sampled on the reference clock
  always_ff @(posedge clk_in) begin
    last_r <= pin_level_out;
    if (clr_in) edges_out <= 0;
    else if (pin_level_out && !last_r) edges_out <= edges_out + 1;
  end
endmodule

// ### bench/sfss_top_test.sv
// self-checking bench for the strap-selected synthesizer control
`timescale 1ns/1ns
module sfss_top_test;
  import sfss_pkg::*;
  localparam int LK = 50;
  localparam int SEC = 100;
  logic clk_in = 0, rst_in = 1, ext_n = 1, nrg = 0, pps = 0, clr = 1;
  logic [2:0] grd = 3'h0, st;
  sfss_ref_t rsel = REF_10M;
  logic pin_i, pin_o, oe, lk, prog_n, r5, tick, praw, pcl, fix;
  int edges, n, ticks, err_count = 0, n_tests = 0;
  logic [31:0] seed = 32'h0000_6109;
  always #5 clk_in = ~clk_in;
  sfss_top #(.LOCK_CYC(LK), .SEC_CYC(SEC), .PPS_HIGH_CYC(10)) u_sfss_top (.clk_in(clk_in), .rst_in(rst_in),
    .ext_reset_n_in(ext_n), .synth_select_straps_grounded_in(grd), .nmea_rate_grounded_in(nrg),
    .ref_freq_sel_in(rsel), .pps_raw_in(pps), .synth_pin_in(pin_i), .synth_pin_out(pin_o), .synth_pin_oe_out(oe),
    .synth_locked_reset_n_out(lk), .program_mode_enable_n_out(prog_n), .synth_select_straps_out(st),
    .nmea_rate_5hz_out(r5), .nmea_tick_out(tick), .pps_raw_out(praw), .pps_clean_out(pcl), .fix_enable_out(fix));
  sfss_board_model u_sfss_board_model (.clk_in(clk_in), .clr_in(clr), .pin_out_in(pin_o), .pin_oe_in(oe),
    .pin_level_out(pin_i), .edges_out(edges));
  // sentence ticks seen while the count window is open
  always @(posedge clk_in) begin
    if (clr) begin
      ticks <= 0;
    end else if (tick) begin
      ticks <= ticks + 1;
    end
  end
  // sentence ticks expected in the 3200-cycle window for the captured rate
  function automatic int exp_ticks(input logic fast);
    return 3200 / (fast ? SEC / NMEA_FAST_HZ : SEC / NMEA_SLOW_HZ);
  endfunction
  // xorshift step for repeatable stimulus
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // rising edges expected in 3200 cycles: 100 * ratio, indexed by code
  function automatic int exp_edges(input sfss_ref_t r, input logic [2:0] c);
    int t10[7] = '{800, 400, 266, 200, 160, 133, 50};
    int t15[7] = '{600, 300, 200, 150, 100, 66, 30};
    int t19[7] = '{400, 200, 133, 80, 66, 50, 25};
    if (c == SEL_OFF) return 0;
    if (r == REF_10M) return t10[c];
    if (r == REF_15M36) return t15[c];
    return t19[c];
  endfunction
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // counts may slip by an edge or two of phase
  task automatic cmp_near(input int got, input int exp);
    n_tests++;
    if (got < exp - 2 || got > exp + 2) begin
      err_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wait_lock();
    n = 0;
    while (lk !== 1'b1 && n < 400) begin
      @(negedge clk_in);
      n++;
    end
  endtask
  task automatic final_report();
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    // every strap code once, reference and rate strap random
    for (int c = 0; c < 8; c++) begin
      seed = xs(seed);
      @(negedge clk_in);
      rst_in = 1;
      grd = ~c[2:0];
      rsel = sfss_ref_t'(seed[1:0]);
      nrg = seed[2];
      repeat (8) @(negedge clk_in);
      rst_in = 0;
      wait_lock();
      cmp_near(n, LK);
      cmp(st, c);
      cmp(oe, c != 7);
      cmp(r5, seed[2]);
      cmp(prog_n, 1'b1);
      grd = seed[5:3];
      nrg = ~nrg;
      clr = 0;
      repeat (3200) @(negedge clk_in);
      clr = 1;
      cmp_near(edges, exp_edges(rsel, c[2:0]));
      cmp_near(ticks, exp_ticks(seed[2]));
      cmp(st, c);
      cmp(r5, seed[2]);
    end
    // grounded reset pin mid-run, straps changed since capture
    ext_n = 0;
    repeat (4) @(negedge clk_in);
    cmp(lk, 1'b0);
    ext_n = 1;
    wait_lock();
    cmp_near(n, LK + 2);
    cmp(st, {29'h0000_0000, ~grd});
    cmp(fix, 1'b0);
    // raw pulse arrives, clean follows on the same edge
    pps = 1;
    repeat (4) @(negedge clk_in);
    cmp(praw, 1'b1);
    cmp(pcl, 1'b1);
    pps = 0;
    repeat (9) @(negedge clk_in);
    cmp(pcl, 1'b0);
    // three warm seconds after the pin reset have passed by now
    repeat (300) @(negedge clk_in);
    cmp(fix, 1'b1);
    final_report();
  end
  // about twice the expected run length
  initial begin
    #600000;
    err_count++;
    final_report();
  end
endmodule
bind sfss_top sfss_sva #(.LOCK_CYC(LOCK_CYC)) u_sfss_sva (.clk_in(clk_in), .rst_in(rst_in),
  .ext_reset_n_in(ext_reset_n_in), .synth_pin_out(synth_pin_out), .synth_pin_oe_out(synth_pin_oe_out),
  .synth_locked_reset_n_out(synth_locked_reset_n_out), .synth_select_straps_out(synth_select_straps_out),
  .nmea_tick_out(nmea_tick_out), .pps_raw_out(pps_raw_out), .pps_clean_out(pps_clean_out));
